// ==== pdm_dma.v ====
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "pdm_consts.vh"

module pdm_dma
#(
  parameter NCH = 8
)
(
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Peripheral request lines, one-cycle pulses
  input  wire [127:0] dma_req,
  input  wire [15:0]  per_ind_off,
  // Peripheral side of the transfer bus
  output reg  [15:0] per_addr_q,
  output reg  [15:0] per_wdata_q,
  output reg         per_rd_q,
  output reg         per_wr_q,
  output reg         per_byte_q,
  input  wire [15:0] per_rdata,
  input  wire        per_clash,
  // DMA RAM side of the transfer bus
  output reg  [15:0] ram_addr_q,
  output reg  [15:0] ram_wdata_q,
  output reg         ram_rd_q,
  output reg         ram_wr_q,
  output reg         ram_byte_q,
  input  wire [15:0] ram_rdata,
  input  wire        ram_clash,
  // Per-channel transfer interrupt pulses
  output reg  [NCH-1:0] irq_q
);

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE  = 4'h1;
  localparam [3:0] S_READ  = 4'h2;
  localparam [3:0] S_WAIT  = 4'h4;
  localparam [3:0] S_WRITE = 4'h8;

  reg  [3:0]  st_q;
  reg  [2:0]  cur_q;
  reg  [3:0]  last_q;

  wire [16*NCH-1:0] ctl_all;
  wire [16*NCH-1:0] trig_all;
  wire [16*NCH-1:0] sta_all;
  wire [16*NCH-1:0] stb_all;
  wire [16*NCH-1:0] pad_all;
  wire [10*NCH-1:0] cnt_all;
  wire [16*NCH-1:0] ptr_all;
  wire [NCH-1:0]    buf_all;
  wire [NCH-1:0]    pend_all;
  wire [NCH-1:0]    pcol_all;
  wire [NCH-1:0]    xcol_all;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire        acc     = psel & penable;
  wire        wr_en   = acc & pwrite & pready;
  wire        ch_area = (paddr[11:8] == 4'h0) && (paddr[4:2] <= `PDM_OFF_CNT)
                        && (paddr[1:0] == 2'h0);
  wire [2:0]  a_ch    = paddr[7:5];
  wire [2:0]  a_reg   = paddr[4:2];
  wire        hit     = ch_area || (paddr == `PDM_ADDR_COLST)
                        || (paddr == `PDM_ADDR_CHST);
  wire        done    = (st_q == S_WRITE);
  wire        col_wr  = wr_en && (paddr == `PDM_ADDR_COLST);

  wire        g_any;
  wire [2:0]  g_idx;

  pdm_arb
  #(
    .N (NCH),
    .W (3)
  )
  u_arb
  (
    .req (pend_all),
    .any (g_any),
    .idx (g_idx)
  );

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1)
    begin : g_ch
      reg  [15:0] ctl_q;
      reg         force_q;
      reg  [6:0]  sel_q;
      reg  [15:0] sta_q;
      reg  [15:0] stb_q;
      reg  [15:0] pad_q;
      reg  [9:0]  cnt_q;
      reg  [15:0] ptr_q;
      reg  [9:0]  idx_q;
      reg         buf_q;
      reg         reqp_q;
      reg         pcol_q;
      reg         xcol_q;

      wire        on     = ctl_q[`PDM_CTL_ON];
      wire        me_wr  = wr_en && ch_area && (a_ch == i);
      wire        me_dn  = done && (cur_q == i);
      wire        me_gr  = (st_q == S_IDLE) && g_any && (g_idx == i);
      wire        last   = (idx_q == cnt_q);
      wire [10:0] nxt    = {1'b0, idx_q} + 11'h001;
      wire [10:0] tot    = {1'b0, cnt_q} + 11'h001;
      wire        halfpt = (nxt == {1'b0, tot[10:1]});
      wire [15:0] step   = ctl_q[`PDM_CTL_BYTE] ? 16'h0001 : 16'h0002;
      wire        ppong  = ctl_q[`PDM_CTL_PPONG];
      wire        oneshot = ctl_q[`PDM_CTL_ONESHOT];
      wire [1:0]  amode  = ctl_q[`PDM_CTL_AM_HI:`PDM_CTL_AM_LO];
      wire        req_hit = on && !force_q && dma_req[sel_q];

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ctl_q   <= `PDM_RST_REG16;
          force_q <= 1'b0;
          sel_q   <= 7'h00;
          sta_q   <= `PDM_RST_REG16;
          stb_q   <= `PDM_RST_REG16;
          pad_q   <= `PDM_RST_REG16;
          cnt_q   <= `PDM_RST_CNT;
          ptr_q   <= `PDM_RST_REG16;
          idx_q   <= `PDM_RST_CNT;
          buf_q   <= 1'b0;
          reqp_q  <= 1'b0;
          pcol_q  <= 1'b0;
          xcol_q  <= 1'b0;
          irq_q[i] <= 1'b0;
        end
        else
        begin
          irq_q[i] <= 1'b0;
          if (!on)
          begin
            idx_q  <= `PDM_RST_CNT;
            buf_q  <= 1'b0;
            ptr_q  <= sta_q;
            reqp_q <= 1'b0;
          end
          else if (me_dn)
          begin
            irq_q[i] <= ctl_q[`PDM_CTL_HALF] ? halfpt : last;
            if (last)
            begin
              idx_q <= `PDM_RST_CNT;
              buf_q <= ppong ? ~buf_q : 1'b0;
              ptr_q <= (ppong && !buf_q) ? stb_q : sta_q;
              if (oneshot && (!ppong || buf_q))
                ctl_q[`PDM_CTL_ON] <= 1'b0;
            end
            else
            begin
              idx_q <= nxt[9:0];
              if (amode == `PDM_AM_POSTINC)
                ptr_q <= ptr_q + step;
            end
          end
          if (req_hit)
            reqp_q <= 1'b1;
          else if (me_gr && !force_q)
            reqp_q <= 1'b0;
          if (me_dn && force_q)
            force_q <= 1'b0;
          // Clash flags: set wins over clear
          if (col_wr && !pwdata[8 + i])
            pcol_q <= 1'b0;
          if (col_wr && !pwdata[i])
            xcol_q <= 1'b0;
          if (me_dn && per_wr_q && per_clash)
            pcol_q <= 1'b1;
          if (me_dn && ram_wr_q && ram_clash)
            xcol_q <= 1'b1;
          if (me_wr)
          begin
            case (a_reg)
              `PDM_OFF_CTL:
                ctl_q <= pwdata[15:0] & `PDM_CTL_MASK;
              `PDM_OFF_TRIG:
              begin
                sel_q <= pwdata[`PDM_TRIG_SEL_W-1:0];
                if (pwdata[`PDM_TRIG_FORCE])
                  force_q <= 1'b1;
              end
              `PDM_OFF_STA: sta_q <= pwdata[15:0];
              `PDM_OFF_STB: stb_q <= pwdata[15:0];
              `PDM_OFF_PAD: pad_q <= pwdata[15:0];
              `PDM_OFF_CNT: cnt_q <= pwdata[9:0];
              default: ;
            endcase
          end
        end
      end

      assign ctl_all[16*i +: 16]  = ctl_q;
      assign trig_all[16*i +: 16] = {force_q, 8'h00, sel_q};
      assign sta_all[16*i +: 16]  = sta_q;
      assign stb_all[16*i +: 16]  = stb_q;
      assign pad_all[16*i +: 16]  = pad_q;
      assign cnt_all[10*i +: 10]  = cnt_q;
      assign ptr_all[16*i +: 16]  = ptr_q;
      assign buf_all[i]           = buf_q;
      assign pend_all[i]          = on && !me_dn && (force_q || reqp_q);
      assign pcol_all[i]          = pcol_q;
      assign xcol_all[i]          = xcol_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Granted channel view
  // ----------------------------------------------------------------
  wire [15:0] g_ctl  = ctl_all[16*g_idx +: 16];
  wire [15:0] g_pad  = pad_all[16*g_idx +: 16];
  wire [15:0] g_ptr  = ptr_all[16*g_idx +: 16];
  wire [15:0] g_base = buf_all[g_idx] ? stb_all[16*g_idx +: 16] : sta_all[16*g_idx +: 16];
  wire [1:0]  g_am   = g_ctl[`PDM_CTL_AM_HI:`PDM_CTL_AM_LO];
  wire [15:0] g_ram  = (g_am == `PDM_AM_PERIND) ? (g_base + per_ind_off) : g_ptr;
  wire [15:0] c_ctl  = ctl_all[16*cur_q +: 16];
  wire        c_byte = c_ctl[`PDM_CTL_BYTE];
  wire [15:0] c_rd   = c_ctl[`PDM_CTL_TOPER] ? ram_rdata : per_rdata;
  wire [15:0] c_data = c_byte ? {8'h00, c_rd[7:0]} : c_rd;

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  // Own bus, CPU never waits for a transfer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q        <= S_IDLE;
      cur_q       <= 3'h0;
      last_q      <= `PDM_RST_LAST;
      per_addr_q  <= 16'h0000;
      per_wdata_q <= 16'h0000;
      per_rd_q    <= 1'b0;
      per_wr_q    <= 1'b0;
      per_byte_q  <= 1'b0;
      ram_addr_q  <= 16'h0000;
      ram_wdata_q <= 16'h0000;
      ram_rd_q    <= 1'b0;
      ram_wr_q    <= 1'b0;
      ram_byte_q  <= 1'b0;
    end
    else
    begin
      case (st_q)
        S_IDLE:
        begin
          if (g_any)
          begin
            st_q       <= S_READ;
            cur_q      <= g_idx;
            per_addr_q <= g_pad;
            ram_addr_q <= g_ram;
            per_byte_q <= g_ctl[`PDM_CTL_BYTE];
            ram_byte_q <= g_ctl[`PDM_CTL_BYTE];
            ram_rd_q   <= g_ctl[`PDM_CTL_TOPER];
            per_rd_q   <= !g_ctl[`PDM_CTL_TOPER];
          end
        end
        S_READ:
        begin
          st_q     <= S_WAIT;
          ram_rd_q <= 1'b0;
          per_rd_q <= 1'b0;
        end
        S_WAIT:
        begin
          st_q   <= S_WRITE;
          if (c_ctl[`PDM_CTL_TOPER])
          begin
            per_wr_q    <= 1'b1;
            per_wdata_q <= c_data;
          end
          else
          begin
            ram_wr_q    <= 1'b1;
            ram_wdata_q <= c_data;
            // Null write only when reading peripheral
            per_wr_q    <= c_ctl[`PDM_CTL_DUMMY_PERIPHERAL_WRITE];
            per_wdata_q <= 16'h0000;
          end
        end
        S_WRITE:
        begin
          st_q     <= S_IDLE;
          per_wr_q <= 1'b0;
          ram_wr_q <= 1'b0;
          last_q   <= {1'b0, cur_q};
        end
        default:
        begin
          st_q     <= S_IDLE;
          per_rd_q <= 1'b0;
          per_wr_q <= 1'b0;
          ram_rd_q <= 1'b0;
          ram_wr_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB read path, one wait state
  // ----------------------------------------------------------------
  reg [15:0] rd_mux;

  always @*
  begin
    rd_mux = 16'h0000;
    if (paddr == `PDM_ADDR_COLST)
      rd_mux = {pcol_all, xcol_all};
    else if (paddr == `PDM_ADDR_CHST)
      rd_mux = {buf_all, 4'h0, last_q};
    else if (ch_area)
    begin
      case (a_reg)
        `PDM_OFF_CTL:  rd_mux = ctl_all[16*a_ch +: 16];
        `PDM_OFF_TRIG: rd_mux = trig_all[16*a_ch +: 16];
        `PDM_OFF_STA:  rd_mux = sta_all[16*a_ch +: 16];
        `PDM_OFF_STB:  rd_mux = stb_all[16*a_ch +: 16];
        `PDM_OFF_PAD:  rd_mux = pad_all[16*a_ch +: 16];
        `PDM_OFF_CNT:  rd_mux = {6'h00, cnt_all[10*a_ch +: 10]};
        default:       rd_mux = 16'h0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (acc && !pready)
    begin
      pready  <= 1'b1;
      pslverr <= !hit;
      prdata  <= (hit && !pwrite) ? {16'h0000, rd_mux} : 32'h00000000;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ==== pdm_consts.vh ====
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH

// ----------------------------------------------------------------
// Register map (word offsets within a channel, byte addresses for shared registers)
// ----------------------------------------------------------------
`define PDM_CH_STRIDE_BIT  5
`define PDM_OFF_CTL        3'h0
`define PDM_OFF_TRIG       3'h1
`define PDM_OFF_STA        3'h2
`define PDM_OFF_STB        3'h3
`define PDM_OFF_PAD        3'h4
`define PDM_OFF_CNT        3'h5
`define PDM_ADDR_COLST     12'h100
`define PDM_ADDR_CHST      12'h104

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define PDM_CTL_ON         15
`define PDM_CTL_BYTE       14
`define PDM_CTL_TOPER      13
`define PDM_CTL_HALF       12
`define PDM_CTL_DUMMY_PERIPHERAL_WRITE      11
`define PDM_CTL_AM_HI      5
`define PDM_CTL_AM_LO      4
`define PDM_CTL_ONESHOT    0
`define PDM_CTL_PPONG      1
`define PDM_CTL_MASK       16'hF833
`define PDM_AM_POSTINC     2'h0
`define PDM_AM_PERIND      2'h2

// ----------------------------------------------------------------
// Trigger select fields
// ----------------------------------------------------------------
`define PDM_TRIG_FORCE     15
`define PDM_TRIG_SEL_W     7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PDM_RST_REG16      16'h0000
`define PDM_RST_CNT        10'h000
`define PDM_RST_LAST       4'hF

`endif

// ==== pdm_arb.v ====
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Fixed priority pick, channel 0 highest
// ----------------------------------------------------------------
module pdm_arb
#(
  parameter N = 8,
  parameter W = 3
)
(
  // Requests
  input  wire [N-1:0] req,
  // Grant
  output reg          any,
  output reg  [W-1:0] idx
);

  integer k;

  always @*
  begin
    any = 1'b0;
    idx = {W{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1)
    begin
      if (req[k])
      begin
        any = 1'b1;
        idx = k[W-1:0];
      end
    end
  end

endmodule

// ==== pdm_props.sv ====
`timescale 1ns/10ps
module pdm_props
#(
  parameter NCH = 8
)
(
  // Clock and reset
  input wire           pclk,
  input wire           presetn,
  // Register bus
  input wire           psel,
  input wire           penable,
  input wire [31:0]    prdata,
  input wire           pready,
  input wire           pslverr,
  // Transfer bus
  input wire [15:0]    per_wdata_q,
  input wire           per_rd_q,
  input wire           per_wr_q,
  input wire           per_byte_q,
  input wire           ram_rd_q,
  input wire           ram_wr_q,
  input wire [NCH-1:0] irq_q
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait)
    else $error("register answer not after one wait");
  property p_err;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_err: assert property (p_err)
    else $error("error answer carries data");
  property p_rd_wr_per;
    per_rd_q |-> ##2 (ram_wr_q && !per_rd_q);
  endproperty
  a_rd_wr_per: assert property (p_rd_wr_per)
    else $error("peripheral read not followed by ram write");
  property p_rd_wr_ram;
    ram_rd_q |-> ##2 (per_wr_q && !ram_wr_q);
  endproperty
  a_rd_wr_ram: assert property (p_rd_wr_ram)
    else $error("ram read not followed by peripheral write");
  property p_space;
    (per_rd_q || ram_rd_q) |=> (!per_rd_q && !ram_rd_q) [*3];
  endproperty
  a_space: assert property (p_space)
    else $error("transfers closer than four cycles");
  property p_null;
    per_wr_q && ram_wr_q |-> per_wdata_q == 16'h0000;
  endproperty
  a_null: assert property (p_null)
    else $error("null write carries data");
  property p_byte;
    per_wr_q && per_byte_q |-> per_wdata_q[15:8] == 8'h00;
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte write upper bits set");
  property p_irq;
    |irq_q |-> $onehot(irq_q) && $past(per_wr_q || ram_wr_q);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without preceding write");
endmodule

bind pdm_dma pdm_props #(.NCH(NCH)) u_props
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .per_wdata_q(per_wdata_q),
  .per_rd_q(per_rd_q), .per_wr_q(per_wr_q), .per_byte_q(per_byte_q),
  .ram_rd_q(ram_rd_q), .ram_wr_q(ram_wr_q), .irq_q(irq_q)
);

// ==== pdm_far_model.sv ====
`timescale 1ns/10ps
module pdm_far_model
(
  // Clock
  input  wire        pclk,
  // Transfer bus from the engine
  input  wire        per_rd_q,
  input  wire        per_wr_q,
  input  wire        ram_rd_q,
  input  wire        ram_wr_q,
  input  wire [15:0] per_addr_q,
  input  wire [15:0] ram_addr_q,
  // Collision injection
  input  wire        clash_on,
  // Answers
  output reg  [15:0] per_rdata,
  output reg  [15:0] ram_rdata,
  output wire        per_clash,
  output wire        ram_clash
);
  initial
  begin
    per_rdata = 16'h0000;
    ram_rdata = 16'h0000;
  end
  // data the cycle after a read
  // Toggling otherwise, so stale data never matches
  always @(posedge pclk)
  begin
    per_rdata <= per_rd_q ? (per_addr_q ^ 16'h5A3C) : ~per_rdata;
    ram_rdata <= ram_rd_q ? (ram_addr_q ^ 16'hC35A) : ~ram_rdata;
  end
  // clash only in a write cycle
  assign per_clash = clash_on & per_wr_q;
  assign ram_clash = clash_on & ram_wr_q;
endmodule

// ==== test_pdm_dma.sv ====
`timescale 1ns/10ps
module test_pdm_dma;
  reg          pclk, presetn, psel, penable, pwrite, clash_on, re, pw, rw;
  reg  [11:0]  paddr;
  reg  [31:0]  pwdata;
  reg  [127:0] dma_req;
  reg  [15:0]  per_ind_off, rq, ra, rd, pa, pd;
  reg  [7:0]   iq;
  wire [31:0]  prdata;
  wire         pready, pslverr, per_rd_q, per_wr_q, per_byte_q, per_clash;
  wire         ram_rd_q, ram_wr_q, ram_byte_q, ram_clash;
  wire [15:0]  per_addr_q, per_wdata_q, per_rdata, ram_addr_q, ram_wdata_q, ram_rdata;
  wire [7:0]   irq_q;
  integer      miscompares, check_count, i, k;

  pdm_dma #(.NCH(8)) dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_req(dma_req), .per_ind_off(per_ind_off), .per_addr_q(per_addr_q),
    .per_wdata_q(per_wdata_q), .per_rd_q(per_rd_q), .per_wr_q(per_wr_q),
    .per_byte_q(per_byte_q), .per_rdata(per_rdata), .per_clash(per_clash),
    .ram_addr_q(ram_addr_q), .ram_wdata_q(ram_wdata_q), .ram_rd_q(ram_rd_q),
    .ram_wr_q(ram_wr_q), .ram_byte_q(ram_byte_q), .ram_rdata(ram_rdata),
    .ram_clash(ram_clash), .irq_q(irq_q)
  );
  pdm_far_model far
  (
    .pclk(pclk), .per_rd_q(per_rd_q), .per_wr_q(per_wr_q), .ram_rd_q(ram_rd_q),
    .ram_wr_q(ram_wr_q), .per_addr_q(per_addr_q), .ram_addr_q(ram_addr_q),
    .clash_on(clash_on), .per_rdata(per_rdata), .ram_rdata(ram_rdata),
    .per_clash(per_clash), .ram_clash(ram_clash)
  );

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task chk(input [39:0] nm, input [15:0] e, input [15:0] s);
  begin
    check_count = check_count + 1;
    if (s !== e)
    begin
      miscompares = miscompares + 1;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [15:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rq = prdata[15:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // Pulse request n (128 means none), then wait for the write cycle
  task go(input [7:0] n);
  begin
    if (n < 8'd128)
    begin
      @(posedge pclk);
      dma_req[n[6:0]] <= 1'b1;
      @(posedge pclk);
      dma_req <= 128'h0;
    end
    i = 0;
    @(posedge pclk);
    while (ram_wr_q !== 1'b1 && per_wr_q !== 1'b1 && i < 40)
    begin
      @(posedge pclk);
      i = i + 1;
    end
    ra = ram_addr_q;
    rd = ram_wdata_q;
    pa = per_addr_q;
    pd = per_wdata_q;
    rw = ram_wr_q;
    pw = per_wr_q;
    @(posedge pclk);
    iq = irq_q;
  end
  endtask
  // pointer and count written while the channel is off
  task cfg(input [11:0] b, input [15:0] sa, sb, pad, cnt, ctl, trg);
  begin
    apb(1'b1, b + 12'h008, sa);
    apb(1'b1, b + 12'h00C, sb);
    apb(1'b1, b + 12'h010, pad);
    apb(1'b1, b + 12'h014, cnt);
    apb(1'b1, b, ctl);
    apb(1'b1, b + 12'h004, trg);
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
  begin
    apb(1'b0, 12'h000, 16'h0000);
    chk("ctl", 16'h0000, rq);
    apb(1'b0, 12'h104, 16'h0000);
    chk("last", 16'h000F, rq);
    apb(1'b1, 12'h020, 16'h7FFF);
    apb(1'b0, 12'h020, 16'h0000);
    chk("mask", 16'h7833, rq);
    apb(1'b1, 12'h024, 16'h7FFF);
    apb(1'b0, 12'h024, 16'h0000);
    chk("sel", 16'h007F, rq);
    apb(1'b0, 12'h0F8, 16'h0000);
    chk("err", 16'h0001, {15'h0000, re});
    apb(1'b1, 12'h020, 16'h0000);
    $display("registers done");
  end
  endtask
  task t_force;
  begin
    cfg(12'h000, 16'h0100, 16'h0000, 16'h0040, 16'h0001, 16'h8001, 16'h800D);
    go(8'd128);
    chk("addr", 16'h0100, ra);
    chk("data", 16'h5A7C, rd);
    chk("irq", 16'h0000, {8'h00, iq});
    apb(1'b0, 12'h004, 16'h0000);
    chk("trig", 16'h000D, rq);
    go(8'd13);
    chk("inc", 16'h0102, ra);
    chk("irq", 16'h0001, {8'h00, iq});
    apb(1'b0, 12'h000, 16'h0000);
    chk("ctl", 16'h0001, rq);
    go(8'd13);
    chk("off", 16'h0000, {14'h0000, pw, rw});
    $display("forced done");
  end
  endtask
  task t_dir;
  begin
    cfg(12'h040, 16'h0200, 16'h0000, 16'h0080, 16'h0000, 16'hE010, 16'h000B);
    go(8'd12);
    chk("none", 16'h0000, {14'h0000, pw, rw});
    repeat (2)
    begin
      go(8'd11);
      chk("paddr", 16'h0080, pa);
      chk("pdata", 16'h005A, pd);
      chk("bytes", 16'h0003, {14'h0000, per_byte_q, ram_byte_q});
      chk("raddr", 16'h0200, ra);
      chk("irq", 16'h0004, {8'h00, iq});
    end
    apb(1'b1, 12'h040, 16'h0000);
    $display("direction done");
  end
  endtask
  task t_ppong;
  begin
    cfg(12'h060, 16'h0300, 16'h0380, 16'h0070, 16'h0000, 16'h8002, 16'h0046);
    for (k = 0; k < 3; k = k + 1)
    begin
      go(8'd70);
      chk("pp", (k == 1) ? 16'h0380 : 16'h0300, ra);
    end
    apb(1'b1, 12'h060, 16'h0000);
    $display("ping-pong done");
  end
  endtask
  task t_null;
  begin
    per_ind_off <= 16'h0010;
    clash_on <= 1'b1;
    // null write only with the direction bit clear
    cfg(12'h080, 16'h0400, 16'h0000, 16'h0090, 16'h0000, 16'h8821, 16'h8000);
    go(8'd128);
    clash_on <= 1'b0;
    chk("pind", 16'h0410, ra);
    chk("null", 16'h0001, {15'h0000, pw});
    chk("data", 16'h5AAC, rd);
    apb(1'b0, 12'h100, 16'h0000);
    chk("clash", 16'h1010, rq);
    apb(1'b1, 12'h100, 16'h0000);
    apb(1'b0, 12'h100, 16'h0000);
    chk("clr", 16'h0000, rq);
    $display("null write done");
  end
  endtask
  // Half-block interrupt, one block per buffer, then channel stops
  task t_half;
  begin
    cfg(12'h0A0, 16'h0500, 16'h0580, 16'h0050, 16'h0003, 16'h9003, 16'h0001);
    for (k = 0; k < 8; k = k + 1)
    begin
      go(8'd1);
      chk("hirq", ((k == 1) || (k == 5)) ? 16'h0020 : 16'h0000, {8'h00, iq});
      chk("pbuf", 16'h0500 + {8'h00, k[2], 4'h0, k[1:0], 1'b0}, ra);
    end
    apb(1'b0, 12'h0A0, 16'h0000);
    chk("ctl", 16'h1003, rq);
    $display("half block done");
  end
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    dma_req = 128'h0;
    per_ind_off = 16'h0000;
    clash_on = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_force;
    t_dir;
    t_ppong;
    t_null;
    t_half;
    report_and_stop;
  end
  // Whole run is under a thousand cycles
  initial
  begin
    #200000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule
